// ==== hdl/twsu_pkg.sv ====
package twsu_pkg;
    // register word addresses
    localparam logic [15:0] ADDR_CONTROL = 16'hfe34;
    localparam logic [15:0] ADDR_BUFFER  = 16'hfe35;
    localparam logic [15:0] ADDR_BAUD    = 16'hfe36;
    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [8:0] RESET_BUFFER  = 9'h000;
    localparam logic [7:0] RESET_BAUD    = 8'h00;
    // control field positions
    localparam int BIT_MODE_HIGH = 7;
    localparam int BIT_MODE_LOW  = 6;
    localparam int BIT_RUN       = 5;
    localparam int BIT_RECEIVE   = 4;
    localparam int BIT_ORDER     = 3;
    localparam int BIT_OVERRUN   = 2;
    localparam int BIT_END       = 1;
    localparam int BIT_IENABLE   = 0;
    // mode codes {high, low}
    localparam logic [1:0] MODE_SYNC   = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h2;
    localparam logic [1:0] MODE_SLAVE  = 2'h3;
    // bits per byte and ninth position
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_POSITION  = 4'h9;
    // interrupt vector reported beside the request
    localparam logic [15:0] IRQ_VECTOR = 16'h003b;
    // master sequencer states
    typedef enum logic [2:0] {
        TWSU_IDLE, TWSU_START, TWSU_LOW, TWSU_HIGH, TWSU_WAITHI
    } twsu_state_type;
endpackage

// ==== hdl/twsu_top.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module twsu_top
    import twsu_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic [8:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output var  logic [8:0]  RDATA,
    // interrupt request
    output var  logic        IRQ,
    output var  logic [15:0] IRQ_VECTOR_OUT,
    // clock line pin
    input  wire logic        SCL_IN,
    output var  logic        SCL_OUT,
    output var  logic        SCL_OE,
    // data line pin
    input  wire logic        SDA_IN,
    output var  logic        SDA_OUT,
    output var  logic        SDA_OE
);
    // synchronisers: first stage read only by the second
    logic [1:0] scl_sync;               // clock line sampler
    logic [1:0] sda_sync;               // data line sampler
    logic       scl_d;                  // previous synced clock
    logic       sda_d;                  // previous synced data
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], SCL_IN};
            sda_sync <= {sda_sync[0], SDA_IN};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end
    wire logic scl = scl_sync[1];       // synced clock line
    wire logic sda = sda_sync[1];       // synced data line
    wire logic scl_rise = scl & ~scl_d;
    wire logic scl_fall = ~scl & scl_d;
    // start: data falls while clock high; stop: data rises while clock high
    wire logic start_det = scl & scl_d & ~sda & sda_d;
    wire logic stop_det  = scl & scl_d & sda & ~sda_d;

    // registers
    logic [7:0] control;                // mode, flags, enables
    logic [8:0] buffer;                 // data buffer, bit8 = ninth bit
    logic [7:0] baud;                   // reload value
    logic [7:0] shifter;                // hidden shifter
    logic [3:0] bitcnt;                 // clocks seen in this byte
    logic [7:0] baud_cnt;               // reload counter
    logic       half_tick;              // half bit period elapsed
    logic       scl_drive;              // internal clock level (1 = release)
    logic       sda_drive;              // internal data level (1 = release)
    logic       hold_low;               // slave holds clock low
    twsu_state_type state;              // master/internal clock sequencer

    wire logic [1:0] mode = {control[BIT_MODE_HIGH], control[BIT_MODE_LOW]};
    wire logic run      = control[BIT_RUN];
    wire logic endf     = control[BIT_END];
    wire logic rec      = control[BIT_RECEIVE];
    wire logic msb      = control[BIT_ORDER];
    wire logic is_sync  = (mode == MODE_SYNC);
    wire logic is_mast  = (mode == MODE_MASTER);
    wire logic is_slave = (mode == MODE_SLAVE);
    wire logic wr_ctl   = WR & (ADDR == ADDR_CONTROL);
    wire logic wr_buf   = WR & (ADDR == ADDR_BUFFER);
    wire logic wr_baud  = WR & (ADDR == ADDR_BAUD);
    // sync mode uses internal clock while baud nonzero is not implied;
    // internal clock is used when the sequencer is driving
    wire logic internal_clk = is_mast | (is_sync & (state != TWSU_IDLE));

    // bit selected for output at the current position
    function automatic logic out_bit(input logic [7:0] s, input logic m);
        out_bit = m ? s[7] : s[0];
    endfunction
    // shifted value with new input bit
    function automatic logic [7:0] shift_in(input logic [7:0] s, input logic m,
                                            input logic b);
        shift_in = m ? {s[6:0], b} : {b, s[7:1]};
    endfunction

    // baud generator: half period (reload+1) cycles, reinit on write
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            baud_cnt  <= RESET_BAUD;
            half_tick <= 1'b0;
        end else if (wr_baud || state == TWSU_IDLE) begin
            baud_cnt  <= wr_baud ? WDATA[7:0] : baud;
            half_tick <= 1'b0;
        end else if (baud_cnt == 8'h00) begin
            baud_cnt  <= baud;
            half_tick <= 1'b1;
        end else begin
            baud_cnt  <= baud_cnt - 8'h01;
            half_tick <= 1'b0;
        end
    end

    // events feeding flags
    logic ev_byte_start;                // begin a byte (load shifter)
    logic ev_use_start;                 // begin with a start bit
    logic lost;                         // arbitration lost
    logic ninth_rise;                   // ninth rising edge (bus modes)
    logic eighth_rise;                  // eighth rising edge
    logic eighth_fall;                  // eighth falling edge (slave)
    // a run write takes its mode from the written value, not the old one:
    // software usually sets mode and run in a single write, and decoding
    // the stale mode there would start the wrong kind of transfer
    always_comb begin
        ev_use_start  = wr_ctl & (WDATA[BIT_MODE_HIGH:BIT_MODE_LOW] == MODE_MASTER)
                      & WDATA[BIT_RUN] & ~run & ~endf;
        ev_byte_start = ev_use_start
                      | (is_mast & wr_ctl & run & endf & ~WDATA[BIT_END])
                      | (wr_ctl & (WDATA[BIT_MODE_HIGH:BIT_MODE_LOW] == MODE_SYNC)
                         & WDATA[BIT_RUN] & ~run);
        eighth_rise = scl_rise & run & (bitcnt == BITS_PER_BYTE - 4'h1);
        ninth_rise  = scl_rise & run & ~is_sync & (bitcnt == BITS_PER_BYTE);
        eighth_fall = is_slave & scl_fall & run & (bitcnt == BITS_PER_BYTE);
        lost = is_mast & scl_rise & run & (bitcnt < BITS_PER_BYTE)
             & sda_drive & ~sda;
    end
    wire logic sync_done = is_sync & eighth_rise;
    wire logic end_set = sync_done | (is_mast & (ninth_rise | stop_det))
                       | eighth_fall | (is_slave & stop_det);
    wire logic slave_go = is_slave & start_det & ~run & ~endf;

    // control register: software writes, hardware set wins over clear
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            control <= RESET_CONTROL;
        end else begin
            logic [7:0] n;
            n = wr_ctl ? WDATA[7:0] : control;
            // flags only software clears: writes of one are not sets
            if (wr_ctl) begin
                n[BIT_OVERRUN] = control[BIT_OVERRUN] & WDATA[BIT_OVERRUN];
                n[BIT_END]     = control[BIT_END] & WDATA[BIT_END];
            end
            if (end_set) n[BIT_END] = 1'b1;
            if ((end_set & endf) | (scl_fall & ~run & ~is_mast)
                | (is_slave & start_det))
                n[BIT_OVERRUN] = 1'b1;
            if (sync_done | lost | ((is_mast | is_slave) & stop_det)
                | (is_slave & ~rec & ninth_rise & sda))
                n[BIT_RUN] = 1'b0;
            if (slave_go) n[BIT_RUN] = 1'b1;
            control <= n;
        end
    end

    // buffer and baud registers
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            buffer <= RESET_BUFFER;
            baud   <= RESET_BAUD;
        end else begin
            if (wr_buf) buffer <= WDATA;
            if (eighth_rise) buffer[7:0] <= shift_in(shifter, msb, sda);
            if (ninth_rise) buffer[8] <= sda;
            if (wr_baud) baud <= WDATA[7:0];
        end
    end

    // shifter and bit counter; always samples the data line
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            shifter <= 8'hff;
            bitcnt  <= 4'h0;
        end else if (ev_byte_start || slave_go || (is_slave && start_det)) begin
            shifter <= buffer[7:0];
            bitcnt  <= 4'h0;
        end else if (is_slave && wr_ctl && run && endf && !WDATA[BIT_END]) begin
            shifter <= buffer[7:0];
            bitcnt  <= 4'h0;
        end else if (scl_rise && run) begin
            if (bitcnt < BITS_PER_BYTE)
                shifter <= shift_in(shifter, msb, sda);
            bitcnt <= (bitcnt == ACK_POSITION - 4'h1) ? 4'h0 : bitcnt + 4'h1;
        end
    end

    // data output level: shifted data, all ones when receiving, ninth bit ack
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sda_drive <= 1'b1;
        end else if (state == TWSU_START) begin
            sda_drive <= 1'b0;
        end else if (!run || lost) begin
            sda_drive <= 1'b1;
        end else if (internal_clk && state != TWSU_LOW) begin
            // own clock released or high: data moves only in the low phase,
            // otherwise a data edge under a high clock reads as start or stop
            // on the bus; the line edges are seen too late to time this
            sda_drive <= sda_drive;
        end else if (bitcnt < BITS_PER_BYTE) begin
            sda_drive <= rec ? 1'b1 : out_bit(shifter, msb);
        end else begin
            sda_drive <= ~rec ? 1'b1 : (is_mast ? buffer[8] : 1'b0);
        end
    end

    // internal clock sequencer with clock synchronisation
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state     <= TWSU_IDLE;
            scl_drive <= 1'b1;
        end else begin
            case (state)
                TWSU_IDLE: begin
                    scl_drive <= 1'b1;
                    if (ev_use_start) state <= TWSU_START;
                    else if (ev_byte_start) state <= TWSU_LOW;
                end
                TWSU_START: if (half_tick) begin
                    scl_drive <= 1'b0;
                    state     <= TWSU_LOW;
                end
                TWSU_LOW: begin
                    scl_drive <= 1'b0;
                    if (!run) state <= TWSU_IDLE;
                    else if (half_tick) begin
                        scl_drive <= 1'b1;
                        state     <= TWSU_WAITHI;
                    end
                end
                TWSU_WAITHI: if (!run) state <= TWSU_IDLE;
                    else if (scl) state <= TWSU_HIGH;
                TWSU_HIGH: if (!run || lost) begin
                    state <= TWSU_IDLE;
                end else if (endf || sync_done) begin
                    state <= TWSU_IDLE;   // byte done: line left released
                end else if (half_tick) begin
                    scl_drive <= 1'b0;
                    state     <= TWSU_LOW;
                end
                default: state <= TWSU_IDLE;
            endcase
        end
    end

    // slave clock hold: pulled low after eighth fall until end cleared
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            hold_low <= 1'b0;
        end else if (eighth_fall) begin
            hold_low <= 1'b1;
        end else if (!is_slave || (wr_ctl && !WDATA[BIT_END])) begin
            hold_low <= 1'b0;
        end
    end

    // pins: open drain in every mode, sync mode pulls the clock low only when internal
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            SCL_OUT <= 1'b0;
            SCL_OE  <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE  <= 1'b0;
        end else begin
            SCL_OUT <= 1'b0;
            SCL_OE  <= (internal_clk & ~scl_drive) | hold_low;
            SDA_OUT <= 1'b0;
            SDA_OE  <= ~sda_drive & (run | state == TWSU_START);
        end
    end

    // read port and interrupt
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            RDATA          <= 9'h000;
            IRQ            <= 1'b0;
            IRQ_VECTOR_OUT <= IRQ_VECTOR;
        end else begin
            IRQ            <= control[BIT_END] & control[BIT_IENABLE];
            IRQ_VECTOR_OUT <= IRQ_VECTOR;
            if (RD) begin
                case (ADDR)
                    ADDR_CONTROL: RDATA <= {1'b0, control};
                    ADDR_BUFFER:  RDATA <= buffer;
                    ADDR_BAUD:    RDATA <= {1'b0, baud};
                    default:      RDATA <= 9'h000;
                endcase
            end else begin
                RDATA <= 9'h000;
            end
        end
    end

    // assertions
    property p_irq;
        @(posedge CLOCK) disable iff (!NRST)
        (control[BIT_END] && control[BIT_IENABLE]) |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_vec;
        @(posedge CLOCK) disable iff (!NRST) IRQ_VECTOR_OUT == 16'h003b;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_endset;
        @(posedge CLOCK) disable iff (!NRST) end_set |=> control[BIT_END];
    endproperty
    a_endset: assert property (p_endset) else $error("end not set");
    property p_lost;
        @(posedge CLOCK) disable iff (!NRST) lost |=> !control[BIT_RUN] ##1 state == TWSU_IDLE;
    endproperty
    a_lost: assert property (p_lost) else $error("loss not handled");
    property p_hold;
        @(posedge CLOCK) disable iff (!NRST) eighth_fall |=> ##1 SCL_OE;
    endproperty
    a_hold: assert property (p_hold) else $error("clock not held");
    property p_od;
        @(posedge CLOCK) disable iff (!NRST) !SCL_OUT && !SDA_OUT;
    endproperty
    a_od: assert property (p_od) else $error("line driven high");
    property p_slavego;
        @(posedge CLOCK) disable iff (!NRST) slave_go |=> control[BIT_RUN] && control[BIT_OVERRUN];
    endproperty
    a_slavego: assert property (p_slavego) else $error("slave start");
    property p_ninth;
        @(posedge CLOCK) disable iff (!NRST) ninth_rise |=> buffer[8] == $past(sda);
    endproperty
    a_ninth: assert property (p_ninth) else $error("bit8 capture");
    property p_baud;
        @(posedge CLOCK) disable iff (!NRST) wr_baud |=> baud_cnt == $past(WDATA[7:0]);
    endproperty
    a_baud: assert property (p_baud) else $error("baud reinit");
    // with our own clock high, the data level must hold still for the
    // whole phase; a slip here would put a false start or stop on the bus
    property p_sdastill;
        @(posedge CLOCK) disable iff (!NRST)
        (is_mast && run && state == TWSU_HIGH && $past(state) == TWSU_HIGH)
        |-> $stable(sda_drive);
    endproperty
    a_sdastill: assert property (p_sdastill) else $error("data moved in high");
    c_master: cover property (@(posedge CLOCK) ev_use_start);
    c_slave: cover property (@(posedge CLOCK) slave_go);
    c_lost: cover property (@(posedge CLOCK) lost);
    c_sync: cover property (@(posedge CLOCK) sync_done);
endmodule
`default_nettype wire

// ==== verif/twsu_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module twsu_bus_model (
    // resolved bus lines
    input  wire logic       scl,
    input  wire logic       sda,
    // scenario controls
    input  wire logic       ack_en,
    input  wire logic       lose,
    input  wire logic       stretch,
    // line pulls, high means pull low
    output var  logic       scl_low,
    output var  logic       sda_low,
    // observed traffic
    output var  logic [7:0] last_byte,
    output var  int         starts
);
    logic [7:0] shift; // bits as seen, first bit ends up high
    int         cnt;   // data bits in this byte, reset by a start or the ack slot
    logic       ack;   // ack slot pull

    initial begin
        scl_low   = 1'b0;
        ack       = 1'b0;
        shift     = 8'h00;
        last_byte = 8'h00;
        cnt       = 0;
        starts    = 0;
    end

    // only pulls low; a released line reads high by its pull-up
    assign sda_low = ack | lose;

    // start seen: data falls while clock high
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            starts++;
        end
    end

    // sample on clock rise; the ninth rise is the ack slot
    always @(posedge scl) begin
        if (cnt == 8) begin
            cnt = 0;
        end else begin
            shift = {shift[6:0], sda};
            cnt++;
            if (cnt == 8) begin
                last_byte = shift;
            end
        end
    end

    // ack after the eighth fall; stretching tests clock sync
    always @(negedge scl) begin
        ack = (cnt == 8) && ack_en;
        if (stretch) begin
            scl_low = 1'b1;
            #150 scl_low = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import twsu_pkg::*;
    ;
    // register port
    logic        CLOCK, NRST, WR, RD;
    logic [15:0] ADDR;
    logic [8:0]  WDATA;
    wire  [8:0]  RDATA;
    wire         IRQ;
    wire  [15:0] vec;
    // pins and resolved lines; any party pulling wins
    wire         SCL_OE, SDA_OE, m_scl, m_sda;
    logic        b_scl, b_sda, ack_en, lose, stretch;
    wire         scl = !(SCL_OE | m_scl | b_scl);
    wire         sda = !(SDA_OE | m_sda | b_sda);
    wire  [7:0]  m_byte;
    int          m_starts;
    // bookkeeping
    int          error_cnt, n_compared, cycles;

    twsu_top dut (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IRQ_VECTOR_OUT(vec), .SCL_IN(scl),
        .SCL_OUT(), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(SDA_OE));
    twsu_bus_model far (.scl(scl), .sda(sda), .ack_en(ack_en), .lose(lose),
        .stretch(stretch), .scl_low(m_scl), .sda_low(m_sda), .last_byte(m_byte),
        .starts(m_starts));

    // 100 mhz clock
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    // hang guard, well above the expected run
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [8:0] d);
        @(posedge CLOCK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLOCK);
        WR    <= 1'b0;
    endtask

    // read strobe, data taken in the following cycle only
    task automatic rc(input logic [15:0] a, input logic [8:0] exp);
        @(posedge CLOCK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLOCK);
        RD   <= 1'b0;
        #1 chk(RDATA, exp);
    endtask

    // bounded wait for the request level
    task automatic wait_irq(input logic lvl);
        int i;
        for (i = 0; i < 3000 && IRQ !== lvl; i++) @(posedge CLOCK);
        chk(IRQ, lvl);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task automatic t_reset();
        rc(ADDR_CONTROL, {1'b0, RESET_CONTROL});
        rc(ADDR_BUFFER, RESET_BUFFER);
        rc(ADDR_BAUD, {1'b0, RESET_BAUD});
        rc(16'hfe37, 9'h000);
        chk(vec, IRQ_VECTOR);
        chk({SCL_OE, SDA_OE}, 2'h0);
    endtask

    // two bytes: msb first acked, then lsb first with no ack
    task automatic t_master();
        stretch <= 1'b1;
        wr(ADDR_BAUD, 9'h002);
        rc(ADDR_BAUD, 9'h002);
        wr(ADDR_BUFFER, 9'h0a5);
        wr(ADDR_CONTROL, 9'h0a9);
        wait_irq(1'b1);
        chk(m_byte, 8'ha5);
        chk(m_starts, 16'h1);
        rc(ADDR_BUFFER, 9'h0a5);
        rc(ADDR_CONTROL, 9'h0ab);
        ack_en <= 1'b0;
        wr(ADDR_BUFFER, 9'h012);
        wr(ADDR_CONTROL, 9'h0a1);
        wait_cyc(2);
        chk(IRQ, 1'b0);
        wait_irq(1'b1);
        chk(m_byte, 8'h48);
        chk(m_starts, 16'h1);
        rc(ADDR_BUFFER, 9'h112);
    endtask

    // bench-driven stop: clock low, data low, release clock, then data
    task automatic t_stop();
        int i;
        stretch <= 1'b0;
        b_scl   <= 1'b1;
        wait_cyc(4);
        b_sda   <= 1'b1;
        wait_cyc(4);
        b_scl   <= 1'b0;
        for (i = 0; i < 500 && scl !== 1'b1; i++) @(posedge CLOCK);
        wait_cyc(4);
        b_sda   <= 1'b0;
        wait_cyc(8);
        // end was still set, so the stop also marks overrun
        rc(ADDR_CONTROL, 9'h087);
        wr(ADDR_CONTROL, 9'h080);
    endtask

    // a rival holds data low while we send ones
    task automatic t_lost();
        int i;
        wr(ADDR_BUFFER, 9'h0ff);
        wr(ADDR_CONTROL, 9'h0a9);
        for (i = 0; i < 200 && SDA_OE !== 1'b1; i++) @(posedge CLOCK);
        lose <= 1'b1;
        wait_cyc(300);
        // judged before the rival lets go: that release is a stop
        chk(IRQ, 1'b0);
        rc(ADDR_CONTROL, 9'h089);
        lose <= 1'b0;
        wait_cyc(8);
    endtask

    // sync mode on the internal clock: the data line loops the byte back
    task automatic t_sync();
        wr(ADDR_BUFFER, 9'h03c);
        wr(ADDR_CONTROL, 9'h029);
        wait_irq(1'b1);
        rc(ADDR_BUFFER, 9'h03c);
        rc(ADDR_CONTROL, 9'h00b);
    endtask

    // bench plays the master at the 80 ns link rate
    task automatic t_slave();
        wr(ADDR_CONTROL, 9'h0d0);
        wait_cyc(4);
        b_sda <= 1'b1;
        wait_cyc(8);
        rc(ADDR_CONTROL, 9'h0f4);
        repeat (8) begin
            b_scl <= 1'b1;
            wait_cyc(4);
            b_scl <= 1'b0;
            wait_cyc(4);
        end
        b_scl <= 1'b1;
        wait_cyc(8);
        b_scl <= 1'b0;
        wait_cyc(4);
        chk(SCL_OE, 1'b1);
        rc(ADDR_CONTROL, 9'h0f6);
        wr(ADDR_CONTROL, 9'h0f0);
        wait_cyc(6);
        chk(SCL_OE, 1'b0);
        wait_cyc(8);
        b_sda <= 1'b0;
        wait_cyc(8);
        rc(ADDR_CONTROL, 9'h0d2);
        rc(ADDR_BUFFER, 9'h000);
    endtask

    // reset, then each scenario in turn
    initial begin
        NRST       = 1'b0;
        WR         = 1'b0;
        RD         = 1'b0;
        ADDR       = 16'h0000;
        WDATA      = 9'h000;
        b_scl      = 1'b0;
        b_sda      = 1'b0;
        ack_en     = 1'b1;
        lose       = 1'b0;
        stretch    = 1'b0;
        error_cnt  = 0;
        n_compared = 0;
        cycles     = 0;
        wait_cyc(4);
        NRST <= 1'b1;
        t_reset();
        t_master();
        t_stop();
        t_lost();
        t_slave();
        t_sync();
        final_report();
    end
endmodule
`default_nettype wire
